// [pid_sleep_wake_pump_staging.v]
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`include "pid_sleep_regs.vh"
module pid_sleep_wake_pump_staging #(
  parameter integer PID_CYC  = 875000,
  parameter integer TENTH_CYC = 12500000,
  parameter integer SEC_CYC  = 125000000,
  parameter integer MS10_CYC = 1250000
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // avalon-mm slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // process inputs
  input  wire [15:0] voltage_feedback_input,
  input  wire [15:0] current_feedback_input,
  input  wire [15:0] frequency_command,
  input  wire [15:0] output_frequency,
  input  wire [15:0] min_output_frequency,
  input  wire [15:0] pid_setpoint,
  input  wire [15:0] p_term,
  input  wire [15:0] i_term,
  input  wire [15:0] d_term,
  input  wire        run_cmd,
  input  wire        jog_active,
  // drive control
  output reg         pid_tick,
  output reg  [15:0] freq_target,
  output reg         motor_run,
  output reg         coast_stop,
  output reg  [15:0] analog_out1,
  output reg  [15:0] analog_out2,
  // pump staging relays
  output reg         stage_up,
  output reg         stage_down,
  output reg         drive_side_contactor,
  output reg         line_side_contactor
);
  localparam [1:0] SW_RUN = 2'd0, SW_SLEEP = 2'd1;
  localparam [1:0] CO_IDLE = 2'd0, CO_GAP = 2'd1, CO_DONE = 2'd2;

  reg [31:0] ctrl_r;
  reg [15:0] sleep_frequency_setting, wake_frequency_setting, sleep_wake_delay;
  reg [15:0] frequency_upper_bound, frequency_lower_bound;
  reg [15:0] upper_bound_stage_delay, lower_bound_stage_delay;
  reg [15:0] contactor_changeover_delay, pump_staging_level;
  reg [15:0] feedback_display_bias, feedback_display_gain;
  reg        xfer_req_r;
  reg        ack_r;
  wire [7:0] control_mode_selector     = ctrl_r[`CTRL_MODE_LSB+7:`CTRL_MODE_LSB];
  wire       stop_method_selector      = ctrl_r[`CTRL_STOP_BIT];
  wire [7:0] analog_out1_source        = ctrl_r[`CTRL_AO1_LSB+7:`CTRL_AO1_LSB];
  wire [7:0] analog_out2_source        = ctrl_r[`CTRL_AO2_LSB+7:`CTRL_AO2_LSB];
  wire [3:0] power_on_monitor_selector = ctrl_r[`CTRL_PON_LSB+3:`CTRL_PON_LSB];

  // one wait state on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  // a write lands on the edge that ends the wait state, as the master sees it
  wire wr_en = avs_write & ack_r;
  wire [3:0] idx = avs_address[5:2];

  // pid tick and pid result
  reg [31:0] pid_cnt_r;
  reg [15:0] pid_out_r;
  reg [16:0] feedback_r;
  always @(posedge clk_sys) begin
    if (rst) begin
      pid_cnt_r <= 32'h0000_0000;
      pid_tick  <= 1'b0;
      pid_out_r <= 16'h0000;
      feedback_r <= 17'h0_0000;
    end else begin
      pid_tick <= 1'b0;
      if (pid_cnt_r == PID_CYC - 1) begin
        pid_cnt_r <= 32'h0000_0000;
        pid_tick  <= 1'b1;
        pid_out_r <= p_term + i_term + d_term;
        feedback_r <= {1'b0, voltage_feedback_input}
                    + {1'b0, current_feedback_input};
      end else begin
        pid_cnt_r <= pid_cnt_r + 32'h0000_0001;
      end
    end
  end

  // scaled display: bias + fb*(gain-bias)/65536
  wire signed [17:0] span = $signed({2'b00, feedback_display_gain})
                          - $signed({2'b00, feedback_display_bias});
  wire signed [35:0] prod = span * $signed({1'b0, feedback_r});
  wire [15:0] disp_val = feedback_display_bias + prod[31:16];
  reg  [15:0] display_r;
  always @(posedge clk_sys) begin
    if (rst) begin
      display_r   <= 16'h0000;
      analog_out1 <= 16'h0000;
      analog_out2 <= 16'h0000;
    end else begin
      display_r   <= (power_on_monitor_selector == `PON_FEEDBACK) ? disp_val
                   : output_frequency;
      analog_out1 <= (analog_out1_source == `AO_FEEDBACK) ? feedback_r[15:0]
                   : output_frequency;
      analog_out2 <= (analog_out2_source == `AO_FEEDBACK) ? feedback_r[15:0]
                   : output_frequency;
    end
  end

  // sleep/wake supervisor with one shared tenth-second counter
  reg [1:0]  sw_state_r;
  reg [31:0] tenth_cnt_r;
  reg [15:0] sw_tmr_r;
  wire sw_en      = (control_mode_selector == `MODE_PID) & ~jog_active;
  wire sleep_cond = (sw_state_r == SW_RUN) & (output_frequency < sleep_frequency_setting);
  wire wake_cond  = (sw_state_r == SW_SLEEP) & (frequency_command > wake_frequency_setting);
  wire pending    = sw_en & (sleep_cond | wake_cond);
  wire sw_expired = pending & (sw_tmr_r >= sleep_wake_delay);
  always @(posedge clk_sys) begin
    if (rst) begin
      sw_state_r  <= SW_RUN;
      tenth_cnt_r <= 32'h0000_0000;
      sw_tmr_r    <= 16'h0000;
    end else begin
      if (!pending) begin
        tenth_cnt_r <= 32'h0000_0000;
        sw_tmr_r    <= 16'h0000;
      end else if (tenth_cnt_r == TENTH_CYC - 1) begin
        tenth_cnt_r <= 32'h0000_0000;
        if (sw_tmr_r != 16'hFFFF) sw_tmr_r <= sw_tmr_r + 16'h0001;
      end else begin
        tenth_cnt_r <= tenth_cnt_r + 32'h0000_0001;
      end
      if (!sw_en) begin
        sw_state_r <= SW_RUN;
      end else if (sw_expired) begin
        sw_tmr_r    <= 16'h0000;
        tenth_cnt_r <= 32'h0000_0000;
        case (sw_state_r)
          SW_RUN:   sw_state_r <= SW_SLEEP;
          SW_SLEEP: sw_state_r <= SW_RUN;
          default:  sw_state_r <= SW_RUN;
        endcase
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      freq_target <= 16'h0000;
      motor_run   <= 1'b0;
      coast_stop  <= 1'b0;
    end else begin
      motor_run  <= run_cmd & (sw_state_r != SW_SLEEP);
      coast_stop <= (sw_state_r == SW_SLEEP) & stop_method_selector;
      if (sw_state_r == SW_SLEEP) begin
        freq_target <= 16'h0000;
      end else if (sleep_cond && frequency_command < min_output_frequency) begin
        freq_target <= min_output_frequency;
      end else begin
        freq_target <= frequency_command;
      end
    end
  end

  // pump staging
  reg [31:0] sec_cnt_r;
  reg [15:0] up_tmr_r, lo_tmr_r;
  // immediate staging gives one pulse per arrival at a bound, not one per cycle
  reg        up_hold_r, lo_hold_r;
  wire [15:0] dev = (pid_setpoint > feedback_r[15:0]) ? pid_setpoint - feedback_r[15:0]
                  : feedback_r[15:0] - pid_setpoint;
  wire dev_ok = (pump_staging_level == 16'h0000) | (dev >= pump_staging_level);
  wire at_up  = (pid_out_r > frequency_upper_bound) & dev_ok;
  wire at_lo  = (pid_out_r < frequency_lower_bound) & dev_ok;
  wire imm    = (pump_staging_level == 16'h0000);
  wire sec_tick = (sec_cnt_r == SEC_CYC - 1);
  always @(posedge clk_sys) begin
    if (rst) begin
      sec_cnt_r  <= 32'h0000_0000;
      up_tmr_r   <= 16'h0000;
      lo_tmr_r   <= 16'h0000;
      up_hold_r  <= 1'b0;
      lo_hold_r  <= 1'b0;
      stage_up   <= 1'b0;
      stage_down <= 1'b0;
    end else begin
      sec_cnt_r <= sec_tick ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001;
      stage_up   <= 1'b0;
      stage_down <= 1'b0;
      if (!at_up) begin
        up_tmr_r  <= 16'h0000;
        up_hold_r <= 1'b0;
      end else if (imm ? !up_hold_r : up_tmr_r >= upper_bound_stage_delay) begin
        stage_up  <= 1'b1;
        up_tmr_r  <= 16'h0000;
        up_hold_r <= imm;
      end else if (sec_tick) up_tmr_r <= up_tmr_r + 16'h0001;
      if (!at_lo) begin
        lo_tmr_r  <= 16'h0000;
        lo_hold_r <= 1'b0;
      end else if (imm ? !lo_hold_r : lo_tmr_r >= lower_bound_stage_delay) begin
        stage_down <= 1'b1;
        lo_tmr_r   <= 16'h0000;
        lo_hold_r  <= imm;
      end else if (sec_tick) lo_tmr_r <= lo_tmr_r + 16'h0001;
    end
  end

  // contactor changeover: open one, wait, close the other
  reg [1:0]  co_state_r;
  reg [31:0] ms_cnt_r;
  reg [15:0] co_tmr_r;
  reg        to_line_r;
  always @(posedge clk_sys) begin
    if (rst) begin
      co_state_r           <= CO_IDLE;
      ms_cnt_r             <= 32'h0000_0000;
      co_tmr_r             <= 16'h0000;
      to_line_r            <= 1'b0;
      drive_side_contactor <= 1'b1;
      line_side_contactor  <= 1'b0;
    end else begin
      case (co_state_r)
        CO_IDLE: begin
          if (xfer_req_r) begin
            to_line_r            <= drive_side_contactor;
            drive_side_contactor <= 1'b0;
            line_side_contactor  <= 1'b0;
            ms_cnt_r             <= 32'h0000_0000;
            co_tmr_r             <= 16'h0000;
            co_state_r           <= CO_GAP;
          end
        end
        CO_GAP: begin
          if (co_tmr_r >= contactor_changeover_delay) begin
            drive_side_contactor <= ~to_line_r;
            line_side_contactor  <= to_line_r;
            co_state_r           <= CO_DONE;
          end else if (ms_cnt_r == MS10_CYC - 1) begin
            ms_cnt_r <= 32'h0000_0000;
            co_tmr_r <= co_tmr_r + 16'h0001;
          end else begin
            ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
          end
        end
        CO_DONE: co_state_r <= CO_IDLE;
        default: co_state_r <= CO_IDLE;
      endcase
    end
  end

  // register bus
  always @(posedge clk_sys) begin
    if (rst) begin
      ack_r                      <= 1'b0;
      xfer_req_r                 <= 1'b0;
      ctrl_r                     <= {24'h00_0000, `MODE_PID};
      sleep_frequency_setting    <= 16'h0000;
      wake_frequency_setting     <= `RST_WAKE_FREQ;
      sleep_wake_delay           <= `RST_SLEEP_DLY;
      frequency_upper_bound      <= `RST_UP_BOUND;
      frequency_lower_bound      <= 16'h0000;
      upper_bound_stage_delay    <= `RST_STAGE_DLY;
      lower_bound_stage_delay    <= `RST_STAGE_DLY;
      contactor_changeover_delay <= `RST_CO_DLY;
      pump_staging_level         <= 16'h0000;
      feedback_display_bias      <= 16'h0000;
      feedback_display_gain      <= 16'h0000;
      avs_readdata               <= 32'h0000_0000;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      xfer_req_r <= 1'b0;
      if (avs_read & ~ack_r) begin
        case (idx)
          `OFS_CTRL:       avs_readdata <= ctrl_r;
          `OFS_SLEEP_FREQ: avs_readdata <= {16'h0000, sleep_frequency_setting};
          `OFS_WAKE_FREQ:  avs_readdata <= {16'h0000, wake_frequency_setting};
          `OFS_SLEEP_DLY:  avs_readdata <= {16'h0000, sleep_wake_delay};
          `OFS_UP_BOUND:   avs_readdata <= {16'h0000, frequency_upper_bound};
          `OFS_LO_BOUND:   avs_readdata <= {16'h0000, frequency_lower_bound};
          `OFS_UP_DLY:     avs_readdata <= {16'h0000, upper_bound_stage_delay};
          `OFS_LO_DLY:     avs_readdata <= {16'h0000, lower_bound_stage_delay};
          `OFS_CO_DLY:     avs_readdata <= {16'h0000, contactor_changeover_delay};
          `OFS_STAGE_LVL:  avs_readdata <= {16'h0000, pump_staging_level};
          `OFS_DISP_BIAS:  avs_readdata <= {16'h0000, feedback_display_bias};
          `OFS_DISP_GAIN:  avs_readdata <= {16'h0000, feedback_display_gain};
          `OFS_STATUS:     avs_readdata <= {24'h00_0000, co_state_r, line_side_contactor,
                                            drive_side_contactor, motor_run, sw_state_r[0],
                                            pending, sw_en};
          `OFS_FEEDBACK:   avs_readdata <= {15'h0000, feedback_r};
          `OFS_DISPLAY:    avs_readdata <= {16'h0000, display_r};
          `OFS_PID_OUT:    avs_readdata <= {16'h0000, pid_out_r};
          default:         avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (wr_en && avs_byteenable[1:0] == 2'b11) begin
        case (idx)
          `OFS_CTRL:       if (avs_byteenable == 4'hF) ctrl_r <= avs_writedata;
          `OFS_SLEEP_FREQ: sleep_frequency_setting <= avs_writedata[15:0];
          `OFS_WAKE_FREQ:  wake_frequency_setting <= avs_writedata[15:0];
          `OFS_SLEEP_DLY:  sleep_wake_delay <= avs_writedata[15:0];
          `OFS_UP_BOUND:   frequency_upper_bound <= avs_writedata[15:0];
          `OFS_LO_BOUND:   frequency_lower_bound <= avs_writedata[15:0];
          `OFS_UP_DLY:     upper_bound_stage_delay <= avs_writedata[15:0];
          `OFS_LO_DLY:     lower_bound_stage_delay <= avs_writedata[15:0];
          `OFS_CO_DLY:     contactor_changeover_delay <= avs_writedata[15:0];
          `OFS_STAGE_LVL:  pump_staging_level <= avs_writedata[15:0];
          `OFS_DISP_BIAS:  feedback_display_bias <= avs_writedata[15:0];
          `OFS_DISP_GAIN:  feedback_display_gain <= avs_writedata[15:0];
          `OFS_STATUS:     xfer_req_r <= avs_writedata[0];
          default:         xfer_req_r <= 1'b0;
        endcase
      end
    end
  end
endmodule

// [pid_sleep_regs.vh]
`ifndef PID_SLEEP_REGS_VH
`define PID_SLEEP_REGS_VH
// register word offsets (address bits 5:2)
`define OFS_CTRL        4'h0
`define OFS_SLEEP_FREQ  4'h1
`define OFS_WAKE_FREQ   4'h2
`define OFS_SLEEP_DLY   4'h3
`define OFS_UP_BOUND    4'h4
`define OFS_LO_BOUND    4'h5
`define OFS_UP_DLY      4'h6
`define OFS_LO_DLY      4'h7
`define OFS_CO_DLY      4'h8
`define OFS_STAGE_LVL   4'h9
`define OFS_DISP_BIAS   4'hA
`define OFS_DISP_GAIN   4'hB
`define OFS_STATUS      4'hC
`define OFS_FEEDBACK    4'hD
`define OFS_DISPLAY     4'hE
`define OFS_PID_OUT     4'hF
// ctrl fields
`define CTRL_MODE_LSB   0
`define CTRL_STOP_BIT   8
`define CTRL_AO1_LSB    12
`define CTRL_AO2_LSB    20
`define CTRL_PON_LSB    28
// selector codes
`define MODE_PID        8'h09
`define AO_FEEDBACK     8'h09
`define PON_FEEDBACK    4'h4
// reset values
`define RST_SLEEP_DLY   16'h0000
`define RST_STAGE_DLY   16'h012C
`define RST_CO_DLY      16'h0064
`define RST_WAKE_FREQ   16'h1770
`define RST_UP_BOUND    16'h0064
// timing
`define CLK_HZ          125000000
`define PID_PERIOD_US   7000
`define MS10_US         10000
`define S1_US           1000000
`endif

// [pid_sleep_wake_pump_staging_properties.sv]
module pid_sleep_wake_pump_staging_properties #(
  parameter integer PID_CYC = 875000
) (
  input wire        clk_sys,
  input wire        rst,
  input wire        run_cmd,
  input wire        jog_active,
  input wire [15:0] frequency_command,
  input wire [15:0] min_output_frequency,
  input wire        pid_tick,
  input wire [15:0] freq_target,
  input wire        motor_run,
  input wire        coast_stop,
  input wire        stage_up,
  input wire        drive_side_contactor,
  input wire        line_side_contactor
);
  timeunit 1ns;
  timeprecision 1ps;
  integer tick_cnt_r;
  reg     seen_r;
  // cycles since the last tick, checked only once a first tick was seen
  always @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_r <= 0;
      seen_r     <= 1'b0;
    end else begin
      tick_cnt_r <= pid_tick ? 0 : tick_cnt_r + 1;
      seen_r     <= seen_r | pid_tick;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_drive_open;
    $fell(drive_side_contactor);
  endsequence
  property p_tick;
    seen_r |-> pid_tick == (tick_cnt_r == PID_CYC - 1);
  endproperty
  a_tick: assert property (p_tick) else $error("pid tick period wrong");
  property p_sleep_stop;
    coast_stop |-> !motor_run && freq_target == 16'h0000;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("asleep but driving");
  property p_jog;
    (jog_active && run_cmd) [*3] |-> motor_run;
  endproperty
  a_jog: assert property (p_jog) else $error("motor stopped during jog");
  property p_no_short;
    !(drive_side_contactor && line_side_contactor);
  endproperty
  a_no_short: assert property (p_no_short) else $error("both contactors on");
  property p_co_gap;
    s_drive_open |-> !line_side_contactor [*4];
  endproperty
  a_co_gap: assert property (p_co_gap) else $error("changeover gap too short");
  property p_co_done;
    s_drive_open |-> ##[1:1000] line_side_contactor;
  endproperty
  a_co_done: assert property (p_co_done) else $error("changeover never closed");
  property p_up_pulse;
    stage_up |=> !stage_up;
  endproperty
  a_up_pulse: assert property (p_up_pulse) else $error("stage up not a pulse");
  property p_target;
    freq_target != 16'h0000 |-> freq_target == $past(frequency_command)
      || freq_target == $past(min_output_frequency);
  endproperty
  a_target: assert property (p_target) else $error("target has no source");
endmodule
bind pid_sleep_wake_pump_staging pid_sleep_wake_pump_staging_properties #(
  .PID_CYC(PID_CYC)
) props_i (.clk_sys, .rst, .run_cmd, .jog_active, .frequency_command,
  .min_output_frequency, .pid_tick, .freq_target, .motor_run, .coast_stop,
  .stage_up, .drive_side_contactor, .line_side_contactor);

// [contactor_model.sv]
module contactor_model #(
  parameter integer ON_CYC  = 8,
  parameter integer OFF_CYC = 3
) (
  input  wire clk_sys,
  input  wire rst,
  input  wire drive_cmd,
  input  wire line_cmd,
  output reg  drive_closed,
  output reg  line_closed,
  output reg  short_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  integer d_cnt;
  integer l_cnt;
  // coils pull in slower than they drop out
  always @(posedge clk_sys) begin
    if (rst) begin
      d_cnt <= 0;
      l_cnt <= 0;
      {drive_closed, line_closed, short_seen} <= 3'b000;
    end else begin
      d_cnt <= (drive_cmd != drive_closed) ? d_cnt + 1 : 0;
      l_cnt <= (line_cmd != line_closed) ? l_cnt + 1 : 0;
      if (d_cnt == (drive_cmd ? ON_CYC : OFF_CYC)) drive_closed <= drive_cmd;
      if (l_cnt == (line_cmd ? ON_CYC : OFF_CYC)) line_closed <= line_cmd;
      short_seen <= short_seen | (drive_closed & line_closed);
    end
  end
endmodule

// [pid_sleep_wake_pump_staging_test.sv]
`include "pid_sleep_regs.vh"
module pid_sleep_wake_pump_staging_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] p, i, d, v, c, pid;
    logic [16:0] fb;
  } row_t;
  reg         clk_sys, rst, avs_read, avs_write, run_cmd, jog_active;
  reg  [5:0]  avs_address;
  reg  [3:0]  avs_byteenable;
  reg  [31:0] avs_writedata, q;
  reg  [15:0] voltage_feedback_input, current_feedback_input, frequency_command;
  reg  [15:0] output_frequency, min_output_frequency, pid_setpoint, p_term, i_term, d_term;
  wire [31:0] avs_readdata;
  wire [15:0] freq_target, analog_out1, analog_out2;
  wire        avs_waitrequest, pid_tick, motor_run, coast_stop, stage_up, stage_down;
  wire        drive_side_contactor, line_side_contactor, short_seen;
  wire [5:0]  ev = {pid_tick, line_side_contactor, stage_down, stage_up, motor_run, coast_stop};
  integer     failures, check_count, n, k;
  row_t       rows [0:2];
  pid_sleep_wake_pump_staging #(.PID_CYC(20), .TENTH_CYC(10), .SEC_CYC(10), .MS10_CYC(5))
    pid_sleep_wake_pump_staging_i (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .voltage_feedback_input, .current_feedback_input, .frequency_command,
    .output_frequency, .min_output_frequency, .pid_setpoint, .p_term, .i_term, .d_term,
    .run_cmd, .jog_active, .pid_tick, .freq_target, .motor_run, .coast_stop,
    .analog_out1, .analog_out2, .stage_up, .stage_down, .drive_side_contactor,
    .line_side_contactor);
  contactor_model contactor_model_i (.clk_sys, .rst, .drive_cmd(drive_side_contactor),
    .line_cmd(line_side_contactor), .drive_closed(), .line_closed(), .short_seen);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task final_report;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      check_count++;
      if (got !== exp) begin
        failures++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // request held until waitrequest is sampled low
  task bus(input rd, input [3:0] idx, input [31:0] d, input [3:0] be);
    begin
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      avs_byteenable <= be;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
        chk("waitrequest", 0, 1);
        final_report();
      end
    end
  endtask
  task wr(input [3:0] idx, input [31:0] d);
    bus(1'b0, idx, d, 4'hF);
  endtask
  task rdchk(input string what, input [3:0] idx, input [31:0] exp, input [31:0] mask);
    begin
      bus(1'b1, idx, 32'h0000_0000, 4'hF);
      chk(what, exp, q & mask);
    end
  endtask
  task wait_on(input integer sel, input integer lim);
    begin
      for (k = 0; k < lim && ev[sel] !== 1'b1; k++) begin
        @(posedge clk_sys);
      end
      if (ev[sel] !== 1'b1) begin
        chk("wait event", sel, 32'hFFFF_FFFF);
        final_report();
      end
    end
  endtask
  initial begin
    {rst, run_cmd, jog_active} = 3'b100;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {40'h0, 4'hF};
    {voltage_feedback_input, current_feedback_input, frequency_command} = 48'h0;
    {output_frequency, min_output_frequency, pid_setpoint, p_term, i_term, d_term} = 96'h0;
    {failures, check_count} = 0;
    rows[0] = {16'h1000, 16'h0200, 16'h0030, 16'h1000, 16'h2000, 16'h1230, 17'h0_3000};
    rows[1] = {16'hFFFF, 16'h0002, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0001, 17'h1_FFFE};
    rows[2] = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    chk("drive_ct", 1, drive_side_contactor);
    rdchk("ctrl", `OFS_CTRL, 32'h0000_0009, 32'h0000_00FF);
    rdchk("sleep_dly", `OFS_SLEEP_DLY, 32'h0000_0000, 32'hFFFF_FFFF);
    rdchk("up_dly", `OFS_UP_DLY, 32'h0000_012C, 32'hFFFF_FFFF);
    rdchk("lo_dly", `OFS_LO_DLY, 32'h0000_012C, 32'hFFFF_FFFF);
    bus(1'b0, `OFS_CTRL, 32'h0000_0000, 4'h3);
    rdchk("ctrl_be", `OFS_CTRL, 32'h0000_0009, 32'h0000_00FF);
    for (int r = 0; r < 3; r++) begin
      {p_term, i_term, d_term} <= {rows[r].p, rows[r].i, rows[r].d};
      {voltage_feedback_input, current_feedback_input} <= {rows[r].v, rows[r].c};
      repeat (2) begin
        wait_on(5, 50);
        @(posedge clk_sys);
      end
      rdchk("pid_out", `OFS_PID_OUT, rows[r].pid, 32'h0000_FFFF);
      rdchk("feedback", `OFS_FEEDBACK, rows[r].fb, 32'h0001_FFFF);
    end
    {voltage_feedback_input, current_feedback_input} <= {16'h1000, 16'h2000};
    output_frequency <= 16'h0200;
    wr(`OFS_DISP_BIAS, 32'h0000_0100);
    wr(`OFS_DISP_GAIN, 32'h0000_0200);
    wr(`OFS_SLEEP_FREQ, 32'h0000_0100);
    wr(`OFS_WAKE_FREQ, 32'h0000_0800);
    wr(`OFS_SLEEP_DLY, 32'h0000_0003);
    wr(`OFS_CTRL, 32'h4000_9109);
    {run_cmd, frequency_command, min_output_frequency} <= {1'b1, 16'h0050, 16'h0080};
    repeat (50) @(posedge clk_sys);
    chk("ao1", 32'h3000, analog_out1);
    chk("ao2", 32'h0200, analog_out2);
    rdchk("display", `OFS_DISPLAY, 32'h0000_0130, 32'h0000_FFFF);
    output_frequency <= 16'h0050;
    repeat (3) @(posedge clk_sys);
    chk("tgt_min", 32'h0080, freq_target);
    repeat (17) @(posedge clk_sys);
    output_frequency <= 16'h0200;
    @(posedge clk_sys);
    output_frequency <= 16'h0050;
    wait_on(0, 100);
    chk("sleep_late", 1, k >= 28);
    chk("run_off", 0, motor_run);
    p_term <= 16'h0042;
    repeat (2) begin
      wait_on(5, 50);
      @(posedge clk_sys);
    end
    rdchk("pid_asleep", `OFS_PID_OUT, 32'h0000_0042, 32'h0000_FFFF);
    frequency_command <= 16'h0900;
    wait_on(1, 100);
    chk("wake_late", 1, k >= 28);
    output_frequency <= 16'h0900;
    repeat (2) @(posedge clk_sys);
    chk("tgt_cmd", 32'h0900, freq_target);
    for (int m = 0; m < 2; m++) begin
      wr(`OFS_CTRL, m ? 32'h0000_9109 : 32'h0000_9100);
      {jog_active, frequency_command, output_frequency} <= {m[0], 32'h0050_0050};
      repeat (60) @(posedge clk_sys);
      chk("no_sleep", 1, motor_run);
      {jog_active, frequency_command, output_frequency} <= {1'b0, 32'h0900_0900};
    end
    wr(`OFS_CO_DLY, 32'h0000_0002);
    wr(`OFS_STATUS, 32'h0000_0001);
    wait_on(4, 300);
    chk("co_gap", 1, k >= 10);
    chk("short", 0, short_seen);
    chk("drive_open", 0, drive_side_contactor);
    wr(`OFS_UP_DLY, 32'h0000_0005);
    wr(`OFS_LO_DLY, 32'h0000_0008);
    wr(`OFS_STAGE_LVL, 32'h0000_0001);
    p_term <= 16'h0100;
    wait_on(2, 100);
    chk("up_delay", 1, k >= 40);
    wr(`OFS_STAGE_LVL, 32'h0000_0000);
    wr(`OFS_LO_BOUND, 32'h0000_0050);
    p_term <= 16'h0010;
    wait_on(3, 100);
    chk("lo_at_once", 1, k < 25);
    final_report();
  end
endmodule
